/* File: pkg/cfc_pkg.sv */
// Constants and types shared by the channel function converter
package cfc_pkg;
   // Function code field, low nine bits of the 12-bit code
   localparam int         CODE_W        = 12;
   localparam logic [8:0] CODE_CHAN_ST  = 9'h001;
   localparam logic [8:0] CODE_EQ_ST    = 9'h002;
   localparam logic [8:0] CODE_MCLR     = 9'h003;
   localparam logic [8:0] CODE_CONN     = 9'h004;
   localparam logic [8:0] CODE_FUNC     = 9'h008;
   localparam logic [8:0] CODE_READ     = 9'h010;
   localparam logic [8:0] CODE_WRITE    = 9'h020;
   localparam logic [8:0] CODE_NOBCD_RD = 9'h050;
   localparam logic [8:0] CODE_NOBCD_WR = 9'h060;
   localparam logic [8:0] CODE_CLR      = 9'h080;
   localparam logic [8:0] CODE_CLR_INT  = 9'h100;
   // Leading octal digit matched against the selector
   localparam logic [2:0] BANK_DOWN     = 3'h5;
   localparam logic [2:0] BANK_UP       = 3'h6;
   // Channel status word layout
   localparam int         STAT_W        = 10;
   localparam int         STAT_REJECT   = 0;
   localparam int         STAT_PARITY   = 1;
   localparam int         STAT_EQ_LSB   = 2;
   // Master clear pulse toward the equipment
   localparam int         CLK_NS        = 40;
   localparam int         MCLR_NS       = 1000;
   localparam logic [7:0] MCLR_CYCLES   =
      8'((MCLR_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [1:0] {CFC_OUT_IDLE, CFC_OUT_WAIT} cfc_out_e;
   typedef enum logic [1:0] {CFC_IN_NONE, CFC_IN_CHAN, CFC_IN_EQ} cfc_in_e;

   // Signals toward the peripheral equipment
   typedef struct packed {
      logic [12:0] data;      // Bit 12 is the odd parity bit
      logic        connect;
      logic        func;
      logic        read;
      logic        write;
      logic        busy;
      logic        mclr;
      logic        nobcd_rd;
      logic        nobcd_wr;
   } cfc_per_s;

   // Pin inputs as sampled through the synchroniser
   typedef struct packed {
      logic        sel_up;
      logic        func_req;
      logic [11:0] func_code;
      logic        out_ready;
      logic [11:0] out_data;
      logic        in_req;
      logic        reply;
      logic        reject;
      logic        par_err;
      logic [7:0]  eq_int;
      logic [11:0] eq_status;
   } cfc_pin_s;
endpackage : cfc_pkg

/* File: verilog/cfc_converter.sv */
// Channel function converter: host code decode and channel signalling
`timescale 1ns/1ps
module cfc_converter (
   input  wire logic                SYS_CLK,
   input  wire logic                RST,
   input  wire logic                SEL_UP,
   input  wire logic                EXT_FUNC_REQ,
   input  wire logic [11:0]         EXT_FUNC_CODE,
   output      logic                EXT_FUNC_DONE,
   input  wire logic                OUT_READY,
   input  wire logic [11:0]         OUT_DATA,
   output      logic                OUT_DONE,
   input  wire logic                ACC_IN_REQ,
   output      logic [11:0]         ACC_IN_DATA,
   output      logic                ACC_IN_DONE,
   input  wire logic                REPLY,
   input  wire logic                REJECT,
   input  wire logic                PAR_ERR,
   input  wire logic [7:0]          EQ_INT,
   input  wire logic [11:0]         EQ_STATUS,
   output      cfc_pkg::cfc_per_s   PER,
   output      logic                INT_30,
   output      logic                INT_40
);
   import cfc_pkg::*;

   cfc_pin_s              pin_a;
   cfc_pin_s              pin_b;
   cfc_pin_s              next_pin_a;

   cfc_out_e              out_st;
   cfc_out_e              next_out_st;
   cfc_in_e               in_sel;
   cfc_in_e               next_in_sel;
   cfc_per_s              next_per;
   logic                  arm_conn;
   logic                  next_arm_conn;
   logic                  arm_func;
   logic                  next_arm_func;
   logic                  rd;
   logic                  next_rd;
   logic                  wr;
   logic                  next_wr;
   logic                  rej;
   logic                  next_rej;
   logic                  perr;
   logic                  next_perr;
   logic [7:0]            mc_cnt;
   logic [7:0]            next_mc_cnt;
   logic                  next_func_done;
   logic                  next_out_done;
   logic                  next_in_done;
   logic [11:0]           next_in_data;
   logic                  next_int_30;
   logic                  next_int_40;

   logic [2:0]            bank;
   logic                  take;
   logic [8:0]            low;
   logic [STAT_W-1:0]     status;
   logic                  clr_all;
   logic                  int_any;

   // Host and equipment pins are asynchronous; two stages before use
   always_comb begin
      next_pin_a = '{sel_up: SEL_UP, func_req: EXT_FUNC_REQ,
                     func_code: EXT_FUNC_CODE, out_ready: OUT_READY,
                     out_data: OUT_DATA, in_req: ACC_IN_REQ,
                     reply: REPLY, reject: REJECT, par_err: PAR_ERR,
                     eq_int: EQ_INT, eq_status: EQ_STATUS};
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         pin_a <= '0;
         pin_b <= '0;
      end else begin
         pin_a <= next_pin_a;
         pin_b <= pin_a;
      end
   end

   assign bank = pin_b.sel_up ? BANK_UP : BANK_DOWN;
   assign take = pin_b.func_req && !EXT_FUNC_DONE
                 && (pin_b.func_code[11:9] == bank);
   assign low  = pin_b.func_code[8:0];
   assign status = {pin_b.eq_int, perr, rej};
   assign int_any = |status;

   always_comb begin
      next_out_st    = out_st;
      next_in_sel    = in_sel;
      next_arm_conn  = arm_conn;
      next_arm_func  = arm_func;
      next_rd        = rd;
      next_wr        = wr;
      next_rej       = rej;
      next_perr      = perr;
      next_mc_cnt    = (mc_cnt != 8'h00) ? mc_cnt - 8'h01 : 8'h00;
      next_per       = PER;
      next_func_done = EXT_FUNC_DONE && pin_b.func_req;
      next_out_done  = OUT_DONE && pin_b.out_ready;
      next_in_done   = ACC_IN_DONE && pin_b.in_req;
      next_in_data   = ACC_IN_DATA;
      clr_all        = 1'b0;
      if (take) begin
         next_func_done = 1'b1;
         case (low)
            CODE_CHAN_ST: next_in_sel = CFC_IN_CHAN;
            CODE_EQ_ST:   next_in_sel = CFC_IN_EQ;
            CODE_MCLR: begin
               clr_all            = 1'b1;
               next_mc_cnt        = MCLR_CYCLES;
               next_per.nobcd_rd  = 1'b0;
               next_per.nobcd_wr  = 1'b0;
               next_rej           = 1'b0;
               next_perr          = 1'b0;
            end
            CODE_CONN:     next_arm_conn = 1'b1;
            CODE_FUNC:     next_arm_func = 1'b1;
            CODE_READ:     next_rd = 1'b1;
            CODE_WRITE:    next_wr = 1'b1;
            CODE_NOBCD_RD: next_per.nobcd_rd = 1'b1;
            CODE_NOBCD_WR: next_per.nobcd_wr = 1'b1;
            CODE_CLR:      clr_all = 1'b1;
            CODE_CLR_INT: begin
               clr_all   = 1'b1;
               next_rej  = 1'b0;
               next_perr = 1'b0;
            end
            // Unlisted codes complete and do nothing
            default: ;
         endcase
      end
      if (clr_all) begin
         next_arm_conn = 1'b0;
         next_arm_func = 1'b0;
         next_rd       = 1'b0;
         next_wr       = 1'b0;
         next_in_sel   = CFC_IN_NONE;
         next_out_st   = CFC_OUT_IDLE;
         next_per.connect = 1'b0;
         next_per.func    = 1'b0;
      end
      case (out_st)
         CFC_OUT_IDLE: begin
            if (pin_b.out_ready && !OUT_DONE && !clr_all) begin
               if (arm_conn || arm_func) begin
                  next_per.data    = {~^pin_b.out_data, pin_b.out_data};
                  next_per.connect = arm_conn;
                  next_per.func    = arm_func && !arm_conn;
                  next_arm_conn    = 1'b0;
                  next_arm_func    = arm_func && arm_conn;
                  next_out_st      = CFC_OUT_WAIT;
               end else if (wr) begin
                  next_per.data = {~^pin_b.out_data, pin_b.out_data};
                  next_out_done = 1'b1;
               end
            end
         end
         CFC_OUT_WAIT: begin
            if ((pin_b.reply || pin_b.reject) && !clr_all) begin
               next_per.connect = 1'b0;
               next_per.func    = 1'b0;
               next_out_done    = 1'b1;
               next_out_st      = CFC_OUT_IDLE;
            end
         end
         default: next_out_st = CFC_OUT_IDLE;
      endcase
      // reject recorded, set wins over clear
      if (out_st == CFC_OUT_WAIT && pin_b.reject) begin
         next_rej = 1'b1;
      end
      if (pin_b.par_err) begin
         next_perr = 1'b1;
      end
      // ten channel status bits or twelve equipment status bits on host input
      if (pin_b.in_req && !ACC_IN_DONE) begin
         next_in_done = 1'b1;
         case (in_sel)
            CFC_IN_CHAN: next_in_data = {2'h0, status};
            CFC_IN_EQ:   next_in_data = pin_b.eq_status;
            default:     next_in_data = 12'h000;
         endcase
      end
      // busy with read or write held
      next_per.read  = next_rd;
      next_per.write = next_wr;
      next_per.busy  = next_rd || next_wr;
      next_per.mclr  = (next_mc_cnt != 8'h00);
      next_int_30 = int_any && !pin_b.sel_up;
      next_int_40 = int_any && pin_b.sel_up;
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         out_st        <= CFC_OUT_IDLE;
         in_sel        <= CFC_IN_NONE;
         arm_conn      <= 1'b0;
         arm_func      <= 1'b0;
         rd            <= 1'b0;
         wr            <= 1'b0;
         rej           <= 1'b0;
         perr          <= 1'b0;
         mc_cnt        <= 8'h00;
         PER           <= '0;
         EXT_FUNC_DONE <= 1'b0;
         OUT_DONE      <= 1'b0;
         ACC_IN_DONE   <= 1'b0;
         ACC_IN_DATA   <= 12'h000;
         INT_30        <= 1'b0;
         INT_40        <= 1'b0;
      end else begin
         out_st        <= next_out_st;
         in_sel        <= next_in_sel;
         arm_conn      <= next_arm_conn;
         arm_func      <= next_arm_func;
         rd            <= next_rd;
         wr            <= next_wr;
         rej           <= next_rej;
         perr          <= next_perr;
         mc_cnt        <= next_mc_cnt;
         PER           <= next_per;
         EXT_FUNC_DONE <= next_func_done;
         OUT_DONE      <= next_out_done;
         ACC_IN_DONE   <= next_in_done;
         ACC_IN_DATA   <= next_in_data;
         INT_30        <= next_int_30;
         INT_40        <= next_int_40;
      end
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   property p_parity;
      (PER.connect || PER.func) |-> (^PER.data);
   endproperty
   a_parity: assert property (p_parity)
      else $error("Forwarded word lacks odd parity");
   property p_bank;
      (pin_b.func_req && !EXT_FUNC_DONE && pin_b.func_code[11:9] != bank)
      |=> !EXT_FUNC_DONE;
   endproperty
   a_bank: assert property (p_bank)
      else $error("Code from other bank was completed");
   property p_int_line;
      int_any |=> (INT_40 == $past(pin_b.sel_up)) && (INT_30 != INT_40);
   endproperty
   a_int_line: assert property (p_int_line)
      else $error("Interrupt on wrong host line");
   property p_mclr;
      (take && low == CODE_MCLR) |=> PER.mclr && !PER.nobcd_rd
         && !PER.nobcd_wr ##1 PER.mclr;
   endproperty
   a_mclr: assert property (p_mclr)
      else $error("Master clear code not carried out");
   property p_read;
      (take && low == CODE_READ) |=> (PER.read && PER.busy) [*2];
   endproperty
   a_read: assert property (p_read)
      else $error("Read state not shown to equipment");
   property p_stall;
      (out_st == CFC_OUT_IDLE && pin_b.out_ready && !OUT_DONE
       && !arm_conn && !arm_func && !wr) |=> !OUT_DONE;
   endproperty
   a_stall: assert property (p_stall)
      else $error("Unarmed output was completed");
   property p_reject;
      (out_st == CFC_OUT_WAIT && pin_b.reject && !take)
      |=> rej && OUT_DONE && !PER.connect;
   endproperty
   a_reject: assert property (p_reject)
      else $error("Reject not recorded or host not released");
   property p_clr_keep;
      (take && low == CODE_CLR && rej) |=> rej && !rd && !wr;
   endproperty
   a_clr_keep: assert property (p_clr_keep)
      else $error("Clear functions lost the reject bit");
   property p_clr_int;
      (take && low == CODE_CLR_INT && out_st == CFC_OUT_IDLE)
      |=> !rej;
   endproperty
   a_clr_int: assert property (p_clr_int)
      else $error("Clear with interrupt left reject set");
   property p_chan_stat;
      (pin_b.in_req && !ACC_IN_DONE && in_sel == CFC_IN_CHAN)
      |=> ACC_IN_DONE && ACC_IN_DATA == {2'h0, $past(status)};
   endproperty
   a_chan_stat: assert property (p_chan_stat)
      else $error("Channel status word not presented");
endmodule : cfc_converter

/* File: tb/cfc_per_model.sv */
// Peripheral equipment model answering Connect and Function words
`timescale 1ns/1ps
module cfc_per_model (
   input  wire logic              SYS_CLK,
   input  wire logic              RST,
   input  wire cfc_pkg::cfc_per_s PER,
   input  wire logic [1:0]        MODE,
   input  wire logic              SLOW,
   output      logic              REPLY,
   output      logic              REJECT
);
   import cfc_pkg::*;
   int wait_cnt;

   // Answer lines fall as soon as the request is withdrawn
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         wait_cnt <= 0;
         REPLY <= 1'b0;
         REJECT <= 1'b0;
      end else if (!(PER.connect || PER.func)) begin
         wait_cnt <= 0;
         REPLY <= 1'b0;
         REJECT <= 1'b0;
      end else if (wait_cnt < (SLOW ? 6 : 1)) begin
         wait_cnt <= wait_cnt + 1;
      end else begin
         REPLY <= (MODE == 2'h0);
         REJECT <= (MODE == 2'h1);
      end
   end
endmodule : cfc_per_model

/* File: tb/tb_channel_function_converter.sv */
// Self-checking bench for the channel function converter
`timescale 1ns/1ps
module tb_channel_function_converter;
   import cfc_pkg::*;
   logic        sys_clk, rst, sel_up, f_req, f_done, o_rdy, o_done;
   logic        i_req, i_done, reply, reject, par_err, slow, int30, int40;
   logic        cn, fn;
   logic [11:0] f_code, o_data, i_data, eq_st;
   logic [7:0]  eq_int;
   logic [1:0]  mode;
   cfc_per_s    per;
   int          n_errors, total_checks, rej, par, n;

   cfc_converter dut_u (.SYS_CLK(sys_clk), .RST(rst), .SEL_UP(sel_up),
      .EXT_FUNC_REQ(f_req), .EXT_FUNC_CODE(f_code), .EXT_FUNC_DONE(f_done),
      .OUT_READY(o_rdy), .OUT_DATA(o_data), .OUT_DONE(o_done),
      .ACC_IN_REQ(i_req), .ACC_IN_DATA(i_data), .ACC_IN_DONE(i_done),
      .REPLY(reply), .REJECT(reject), .PAR_ERR(par_err), .EQ_INT(eq_int),
      .EQ_STATUS(eq_st), .PER(per), .INT_30(int30), .INT_40(int40));
   cfc_per_model per_u (.SYS_CLK(sys_clk), .RST(rst), .PER(per),
      .MODE(mode), .SLOW(slow), .REPLY(reply), .REJECT(reject));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   function automatic logic [11:0] stat();
      return {2'b00, eq_int, 1'(par), 1'(rej)};
   endfunction : stat

   task automatic do_reset;
      rst = 1'b1;
      f_req = 1'b0;
      o_rdy = 1'b0;
      i_req = 1'b0;
      rej = 0;
      par = 0;
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
   endtask : do_reset

   // Wrong-bank codes must never complete
   task automatic external_function_instruction(input logic [8:0] code, input bit take);
      int k;
      @(negedge sys_clk);
      f_code = {(sel_up ^ !take) ? BANK_UP : BANK_DOWN, code};
      f_req = 1'b1;
      for (k = 0; k < 20 && !f_done; k++) @(negedge sys_clk);
      chk(f_done, take);
      f_req = 1'b0;
      for (k = 0; k < 20 && f_done; k++) @(negedge sys_clk);
   endtask : external_function_instruction

   task automatic outw(input logic [11:0] w, input bit ok);
      int k;
      @(negedge sys_clk);
      cn = 1'b0;
      fn = 1'b0;
      o_data = w;
      o_rdy = 1'b1;
      for (k = 0; k < 30 && !o_done; k++) begin
         @(negedge sys_clk);
         cn |= per.connect;
         fn |= per.func;
      end
      chk(o_done, ok);
      if (ok) chk(per.data, {~^w, w});
      o_rdy = 1'b0;
      for (k = 0; k < 20 && o_done; k++) @(negedge sys_clk);
   endtask : outw

   task automatic input_to_accumulator(input logic [11:0] exp);
      int k;
      @(negedge sys_clk);
      i_req = 1'b1;
      for (k = 0; k < 20 && !i_done; k++) @(negedge sys_clk);
      chk(i_data, exp);
      i_req = 1'b0;
      for (k = 0; k < 20 && i_done; k++) @(negedge sys_clk);
   endtask : input_to_accumulator

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // Whole sequence needs a few hundred cycles
   initial begin
      #800000;
      n_errors++;
      give_verdict();
   end

   initial begin
      n_errors = 0;
      total_checks = 0;
      rst = 1'b1;
      {sel_up, par_err, slow, mode, f_code, o_data, eq_st, eq_int} = '0;
      void'($urandom(60));
      do_reset();
      for (int s = 0; s < 2; s++) begin
         sel_up = s[0];
         repeat (4) @(negedge sys_clk);
         external_function_instruction(CODE_CHAN_ST, 0);
         external_function_instruction(CODE_CHAN_ST, 1);
         eq_int = 8'($urandom_range(255, 1));
         repeat (6) @(negedge sys_clk);
         chk({int40, int30}, {s[0], !s[0]});
         input_to_accumulator(stat());
         eq_st = 12'($urandom);
         external_function_instruction(CODE_EQ_ST, 1);
         input_to_accumulator(eq_st);
         eq_int = 8'h00;
      end
      $display("Bank and status test done");
      par_err = 1'b1;
      repeat (3) @(negedge sys_clk);
      par_err = 1'b0;
      par = 1;
      for (int m = 0; m < 2; m++) begin
         mode = 2'(m);
         slow = m[0];
         external_function_instruction(CODE_CONN, 1);
         outw(12'($urandom), 1);
         chk(cn, 1'b1);
         rej |= m;
         external_function_instruction(CODE_CHAN_ST, 1);
         input_to_accumulator(stat());
      end
      chk({int40, int30}, 2'b10);
      external_function_instruction(CODE_CLR, 1);
      external_function_instruction(CODE_CHAN_ST, 1);
      input_to_accumulator(stat());
      external_function_instruction(CODE_CLR_INT, 1);
      rej = 0;
      par = 0;
      external_function_instruction(CODE_CHAN_ST, 1);
      input_to_accumulator(stat());
      repeat (4) @(negedge sys_clk);
      chk({int40, int30}, 2'b00);
      mode = 2'h0;
      external_function_instruction(CODE_FUNC, 1);
      outw(12'($urandom), 1);
      chk(fn, 1'b1);
      $display("Connect and function test done");
      outw(12'($urandom), 0);
      do_reset();
      mode = 2'h2;
      external_function_instruction(CODE_CONN, 1);
      outw(12'($urandom), 0);
      do_reset();
      $display("Stall test done");
      external_function_instruction(CODE_NOBCD_RD, 1);
      external_function_instruction(CODE_NOBCD_WR, 1);
      external_function_instruction(CODE_READ, 1);
      chk({per.read, per.busy}, 2'h3);
      chk({per.nobcd_rd, per.nobcd_wr}, 2'h3);
      external_function_instruction(CODE_CLR, 1);
      chk({per.read, per.busy}, 2'h0);
      chk({per.nobcd_rd, per.nobcd_wr}, 2'h3);
      external_function_instruction(CODE_WRITE, 1);
      outw(12'($urandom), 1);
      chk({per.write, per.busy}, 2'h3);
      external_function_instruction(CODE_CLR_INT, 1);
      chk({per.write, per.busy}, 2'h0);
      chk({per.nobcd_rd, per.nobcd_wr}, 2'h3);
      for (n = 0; n < 20 && per.busy; n++) @(negedge sys_clk);
      chk(per.busy, 1'b0);
      @(negedge sys_clk);
      f_code = {BANK_UP, CODE_MCLR};
      f_req = 1'b1;
      n = 0;
      repeat (60) begin
         @(negedge sys_clk);
         if (per.mclr) n++;
         if (f_done) f_req = 1'b0;
      end
      chk(16'(n), 16'(MCLR_CYCLES));
      chk({per.nobcd_rd, per.nobcd_wr}, 2'h0);
      $display("Read write and clear test done");
      give_verdict();
   end
endmodule : tb_channel_function_converter
